// File: hdl/srseq_seq.sv
// rolling and global shutter sequencer for a split-array sensor
// Overview of operation
// - both halves are swept together by one row offset, from the centre row out to the edge.
// - in rolling mode a start wave switches each row in turn from clean to exposing.
// - in rolling mode a readout wave follows in the same order so every row gets equal exposure.
// - each wave steps one row every ten microseconds of clock time.
// - in continuous rolling each row starts its next exposure as its readout ends.
// - at full rate the readout wave restarts at the centre as soon as it reaches the edge.
// - in global mode all pixels are held clean until the exposure begins.
// - in global mode all pixels start exposing together and transfer charge together.
// - in global overlap mode the next exposure runs while the last one is read out.
// - global mode adds a reference readout to every signal readout, halving the frame rate.
// - rolling or global is chosen by the user; a rolling-only variant never enters global.
// - the global charge transfer lasts two microseconds, the least gap between exposures.
// - in global mode the reference frame is read first, then the signal frame to subtract.
`timescale 1ns/1ns
module srseq_seq
  import srseq_pkg::*;
#(
  parameter bit HAS_GLOBAL = 1'b1
) (
  input  wire logic             clock_in,
  input  wire logic             reset_n_in,
  input  wire logic             acq_run_in,
  input  wire logic             global_sel_in,
  input  wire logic             overlap_in,
  input  wire logic             continuous_in,
  input  wire logic [EXP_W-1:0] exp_rows_in,
  input  wire logic             cmd_ready_in,
  output logic                  cmd_valid_out,
  output logic [CMD_W-1:0]      cmd_data_out,
  output logic                  global_clean_out,
  output logic                  global_expose_out,
  output logic                  global_xfer_out,
  output logic                  busy_out,
  output logic                  mode_global_out
);
  srseq_state_t      state_q;
  logic              mode_q;
  logic              ovl_q;
  logic              cont_q;
  logic [CNT_W-1:0]  cnt_q;
  logic              in_ready;
  logic              exp_run_q;
  logic [ROW_W-1:0]  exp_ptr_q;
  logic              exp_pend_q;
  logic [EXP_W-1:0]  exp_cnt_q;
  logic              rd_run_q;
  logic [ROW_W-1:0]  rd_ptr_q;
  srseq_kind_t       rd_kind_q;
  logic              reexp_q;
  logic              ovl_exp_q;
  logic [XFER_W-1:0] xfer_cnt_q;
  logic              tick_s;
  logic              tick_r;
  logic              start_ev;
  logic              rd_ev;
  logic              rd_last;
  logic              exp_done;
  logic              launch;
  logic              g_expose;
  logic              g_go_xfer;
  logic              g_go_read;
  logic              sel_global;
  logic              wr_valid;
  logic [CMD_W-1:0]  wr_data;

  // the row timer freezes on back-pressure so no command is dropped
  assign tick_s     = in_ready && (cnt_q == EV_START);
  assign tick_r     = in_ready && (cnt_q == EV_READ);
  assign exp_done   = (exp_cnt_q >= exp_rows_in);
  assign start_ev   = tick_s && exp_run_q && (state_q == S_ROLL);
  assign rd_ev      = tick_r && rd_run_q;
  assign rd_last    = rd_ev && (rd_ptr_q == ROW_LAST);
  assign launch     = tick_s && (state_q == S_ROLL) && exp_pend_q && !rd_run_q && exp_done;
  assign g_expose   = (state_q == S_GEXP) || ((state_q == S_GREAD) && ovl_exp_q);
  assign g_go_xfer  = (state_q == S_GEXP) && tick_s && exp_done;
  assign g_go_read  = (state_q == S_GXFER) && (xfer_cnt_q == XFER_TOP);
  assign sel_global = global_sel_in && HAS_GLOBAL;
  assign wr_valid   = start_ev || rd_ev;
  assign wr_data    = start_ev ? {1'b0, K_START, exp_ptr_q} : {reexp_q, rd_kind_q, rd_ptr_q};

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      cnt_q <= CNT_ZERO;
    end else if (in_ready) begin
      cnt_q <= (cnt_q == ROW_TOP) ? CNT_ZERO : cnt_q + 1'b1;
    end
  end

  // mode bits are only sampled in idle, so a sweep never changes mode midway
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      state_q <= S_IDLE;
      mode_q  <= 1'b0;
      ovl_q   <= 1'b0;
      cont_q  <= 1'b0;
    end else begin
      case (state_q)
        S_IDLE: begin
          mode_q <= sel_global;
          ovl_q  <= overlap_in;
          cont_q <= continuous_in;
          if (acq_run_in) begin
            state_q <= sel_global ? S_GEXP : S_ROLL;
          end
        end
        S_ROLL: begin
          if (!exp_run_q && !exp_pend_q && !rd_run_q) begin
            state_q <= S_IDLE;
          end
        end
        S_GEXP: begin
          if (g_go_xfer) begin
            state_q <= S_GXFER;
          end
        end
        S_GXFER: begin
          if (g_go_read) begin
            state_q <= S_GREAD;
          end
        end
        S_GREAD: begin
          if (rd_last && (rd_kind_q == K_RSUB)) begin
            state_q <= ovl_exp_q ? S_GEXP : S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // start wave of the first rolling exposure
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      exp_run_q <= 1'b0;
      exp_ptr_q <= ROW_FIRST;
    end else if ((state_q == S_IDLE) && acq_run_in && !sel_global) begin
      exp_run_q <= 1'b1;
      exp_ptr_q <= ROW_FIRST;
    end else if (start_ev) begin
      exp_run_q <= (exp_ptr_q != ROW_LAST);
      exp_ptr_q <= exp_ptr_q + 1'b1;
    end
  end

  // exposure length counted in row periods
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      exp_cnt_q  <= EXP_ZERO;
      exp_pend_q <= 1'b0;
    end else if (state_q == S_IDLE) begin
      exp_cnt_q  <= EXP_ZERO;
      exp_pend_q <= acq_run_in && !sel_global;
    end else if (launch || g_go_xfer) begin
      exp_cnt_q  <= EXP_ZERO;
      exp_pend_q <= cont_q && acq_run_in && launch;
    end else if (tick_s && (exp_pend_q || g_expose) && (exp_cnt_q != EXP_MAX)) begin
      exp_cnt_q <= exp_cnt_q + 1'b1;
    end
  end

  // shared readout sweep, reference then subtracted signal in global mode
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      rd_run_q  <= 1'b0;
      rd_ptr_q  <= ROW_FIRST;
      rd_kind_q <= K_RSIG;
      reexp_q   <= 1'b0;
      ovl_exp_q <= 1'b0;
    end else if (launch) begin
      rd_run_q  <= 1'b1;
      rd_ptr_q  <= ROW_FIRST;
      rd_kind_q <= K_RSIG;
      reexp_q   <= cont_q && acq_run_in;
    end else if (g_go_read) begin
      rd_run_q  <= 1'b1;
      rd_ptr_q  <= ROW_FIRST;
      rd_kind_q <= K_RREF;
      reexp_q   <= 1'b0;
      ovl_exp_q <= ovl_q && acq_run_in;
    end else if (rd_ev) begin
      rd_ptr_q <= rd_last ? ROW_FIRST : rd_ptr_q + 1'b1;
      if (rd_last) begin
        rd_run_q  <= (rd_kind_q == K_RREF);
        rd_kind_q <= (rd_kind_q == K_RREF) ? K_RSUB : rd_kind_q;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      xfer_cnt_q <= XFER_ZERO;
    end else if (state_q == S_GXFER) begin
      xfer_cnt_q <= xfer_cnt_q + 1'b1;
    end else begin
      xfer_cnt_q <= XFER_ZERO;
    end
  end

  // array-wide levels follow the state one cycle later
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      global_clean_out  <= 1'b0;
      global_expose_out <= 1'b0;
      global_xfer_out   <= 1'b0;
      busy_out          <= 1'b0;
      mode_global_out   <= 1'b0;
    end else begin
      global_clean_out  <= (state_q == S_IDLE) ? sel_global
                         : (mode_q && !g_expose && (state_q != S_GXFER));
      global_expose_out <= g_expose;
      global_xfer_out   <= (state_q == S_GXFER);
      busy_out          <= (state_q != S_IDLE);
      mode_global_out   <= mode_q;
    end
  end

  srseq_fifo #(
    .W     (CMD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock_in      (clock_in),
    .reset_n_in    (reset_n_in),
    .in_valid_in   (wr_valid),
    .in_data_in    (wr_data),
    .in_ready_out  (in_ready),
    .out_valid_out (cmd_valid_out),
    .out_data_out  (cmd_data_out),
    .out_ready_in  (cmd_ready_in)
  );

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_xfer_end;
    (state_q == S_GXFER) && (xfer_cnt_q == XFER_TOP);
  endsequence

  sequence s_ref_begin;
    (state_q == S_GREAD) && rd_run_q && (rd_kind_q == K_RREF) && (rd_ptr_q == ROW_FIRST);
  endsequence

  a_mode_hold: assert property ($changed(mode_q) |-> $past(state_q) == S_IDLE)
    else $error("mode changed during acquisition");
  a_variant_roll: assert property (!HAS_GLOBAL |-> !mode_q && state_q != S_GEXP)
    else $error("global mode on rolling-only variant");
  a_xfer_start: assert property ($rose(state_q == S_GXFER) |-> xfer_cnt_q == XFER_ZERO)
    else $error("transfer count not cleared");
  a_xfer_to_read: assert property (s_xfer_end |=> s_ref_begin)
    else $error("reference readout did not follow transfer");
  a_xfer_len: assert property ($fell(state_q == S_GXFER) |->
    $past(xfer_cnt_q) == XFER_TOP)
    else $error("transfer shorter than required");
  a_clean_excl: assert property (global_clean_out |->
    !global_expose_out && !global_xfer_out)
    else $error("clean asserted while exposing");
  a_row_step: assert property (rd_ev && !rd_last |=> rd_ptr_q == $past(rd_ptr_q) + 1'b1)
    else $error("readout row order broken");
  a_row_pace: assert property (rd_ev |=> !rd_ev [*8])
    else $error("rows read too close together");
  a_cont_restart: assert property (launch && cont_q && acq_run_in |=>
    exp_pend_q && exp_cnt_q == EXP_ZERO && rd_ptr_q == ROW_FIRST)
    else $error("continuous rolling did not restart");
  a_ovl_expose: assert property (g_go_read && ovl_q && acq_run_in |=>
    ##1 global_expose_out)
    else $error("overlap exposure not running during readout");
  a_ref_then_sub: assert property (rd_last && rd_kind_q == K_RREF |=>
    rd_run_q && rd_kind_q == K_RSUB)
    else $error("signal readout did not follow reference");
endmodule : srseq_seq

// File: pkg/srseq_pkg.sv
// constants and types shared by the shutter readout sequencer
package srseq_pkg;
  localparam int CLK_NS    = 40;
  localparam int ROW_NS    = 10000;
  localparam int XFER_NS   = 2000;
  localparam int ROW_CYC   = (ROW_NS + CLK_NS - 1) / CLK_NS;
  localparam int XFER_CYC  = (XFER_NS + CLK_NS - 1) / CLK_NS;
  localparam int ROWS      = 1080;
  localparam int ROW_W     = 11;
  localparam int CNT_W     = 8;
  localparam int XFER_W    = 6;
  localparam int EXP_W     = 16;
  localparam int CMD_W     = 14;
  localparam int FIFO_DEPTH = 8;
  localparam logic [ROW_W-1:0]  ROW_FIRST = 11'h000;
  localparam logic [ROW_W-1:0]  ROW_LAST  = ROW_W'(ROWS - 1);
  localparam logic [CNT_W-1:0]  CNT_ZERO  = 8'h00;
  localparam logic [CNT_W-1:0]  ROW_TOP   = CNT_W'(ROW_CYC - 1);
  localparam logic [CNT_W-1:0]  EV_START  = 8'h00;
  localparam logic [CNT_W-1:0]  EV_READ   = 8'h01;
  localparam logic [XFER_W-1:0] XFER_ZERO = 6'h00;
  localparam logic [XFER_W-1:0] XFER_TOP  = XFER_W'(XFER_CYC - 1);
  localparam logic [EXP_W-1:0]  EXP_ZERO  = 16'h0000;
  localparam logic [EXP_W-1:0]  EXP_MAX   = 16'hffff;

  // command kinds sent to the row drivers
  typedef enum logic [1:0] {
    K_START = 2'h0,
    K_RSIG  = 2'h1,
    K_RREF  = 2'h2,
    K_RSUB  = 2'h3
  } srseq_kind_t;

  // gray along idle-gexp-gxfer-gread, idle-roll
  typedef enum logic [2:0] {
    S_IDLE  = 3'h0,
    S_GEXP  = 3'h1,
    S_GXFER = 3'h3,
    S_GREAD = 3'h2,
    S_ROLL  = 3'h4
  } srseq_state_t;
endpackage : srseq_pkg

// File: hdl/srseq_fifo.sv
// command fifo with registered read side
`timescale 1ns/1ns
module srseq_fifo #(
  parameter int W     = 14,
  parameter int DEPTH = 8
) (
  input  wire logic         clock_in,
  input  wire logic         reset_n_in,
  input  wire logic         in_valid_in,
  input  wire logic [W-1:0] in_data_in,
  output logic              in_ready_out,
  output logic              out_valid_out,
  output logic [W-1:0]      out_data_out,
  input  wire logic         out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          wr;
  logic          rd;

  assign in_ready_out = (cnt_q != FULL);
  assign wr = in_valid_in && in_ready_out;
  assign rd = (cnt_q != '0) && (!out_valid_out || out_ready_in);

  always_ff @(posedge clock_in) begin
    if (wr) begin
      mem_q[wp_q] <= in_data_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (wr) begin
        wp_q <= wp_q + 1'b1;
      end
      if (rd) begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
    end
  end

  // output stage stalls while the drivers hold ready low
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      out_valid_out <= 1'b0;
      out_data_out  <= '0;
    end else if (rd) begin
      out_valid_out <= 1'b1;
      out_data_out  <= mem_q[rp_q];
    end else if (out_ready_in) begin
      out_valid_out <= 1'b0;
    end
  end
endmodule : srseq_fifo

// File: sim/srseq_rowdrv_model.sv
// row driver model that takes sequencer commands, with stall control
`timescale 1ns/1ns
module srseq_rowdrv_model
  import srseq_pkg::*;
(
  input  wire logic             clock_in,
  input  wire logic             reset_n_in,
  input  wire logic             stall_in,
  input  wire logic             cmd_valid_in,
  input  wire logic [CMD_W-1:0] cmd_data_in,
  output logic                  cmd_ready_out,
  output logic                  took_out,
  output logic [CMD_W-1:0]      word_out
);
  // ready changes only after an edge, like real drivers
  always_ff @(posedge clock_in) begin
    cmd_ready_out <= reset_n_in & ~stall_in;
    took_out      <= cmd_valid_in & cmd_ready_out;
    word_out      <= cmd_data_in;
  end
endmodule : srseq_rowdrv_model

// File: sim/srseq_seq_bench.sv
// self-checking bench for the shutter readout sequencer
`timescale 1ns/1ns
module srseq_seq_bench;
  import srseq_pkg::*;
  logic clock_in = 0, reset_n_in = 0, acq_run_in = 0, global_sel_in = 0;
  logic overlap_in = 0, continuous_in = 0, stall = 0, rnd_on = 0;
  logic [EXP_W-1:0] exp_rows_in = 16'h0002;
  logic cmd_ready, cmd_valid, took, ro_valid, ro_mode, ro_exp;
  logic [CMD_W-1:0] cmd_data, word;
  logic g_clean, g_exp, g_xfer, busy, mode_g;
  logic [CMD_W-1:0] exp_start[$], exp_read[$];
  int n_mismatch = 0, n_compared = 0, cyc = 0, last = -1, xcnt = 0;
  int seed = 32'h680e2669;

  srseq_seq #(.HAS_GLOBAL(1'b1)) uut (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .acq_run_in(acq_run_in), .global_sel_in(global_sel_in), .overlap_in(overlap_in),
    .continuous_in(continuous_in), .exp_rows_in(exp_rows_in), .cmd_ready_in(cmd_ready),
    .cmd_valid_out(cmd_valid), .cmd_data_out(cmd_data), .global_clean_out(g_clean),
    .global_expose_out(g_exp), .global_xfer_out(g_xfer), .busy_out(busy),
    .mode_global_out(mode_g));
  // rolling-only variant sees the same requests
  srseq_seq #(.HAS_GLOBAL(1'b0)) uut_ro (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .acq_run_in(acq_run_in), .global_sel_in(global_sel_in), .overlap_in(overlap_in),
    .continuous_in(continuous_in), .exp_rows_in(exp_rows_in), .cmd_ready_in(1'b1),
    .cmd_valid_out(ro_valid), .cmd_data_out(), .global_clean_out(),
    .global_expose_out(ro_exp), .global_xfer_out(), .busy_out(), .mode_global_out(ro_mode));
  srseq_rowdrv_model model (.clock_in(clock_in), .reset_n_in(reset_n_in), .stall_in(stall),
    .cmd_valid_in(cmd_valid), .cmd_data_in(cmd_data), .cmd_ready_out(cmd_ready),
    .took_out(took), .word_out(word));

  always #20 clock_in = ~clock_in;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test

  task automatic do_reset();
    reset_n_in <= 1'b0;
    acq_run_in <= 1'b0;
    repeat (5) @(posedge clock_in);
    reset_n_in <= 1'b1;
    last = -1;
    @(posedge clock_in);
    #1;
    check("busy after reset", busy, 0);
    check("valid after reset", cmd_valid, 0);
    // leave on an edge so the next requests are driven there
    @(posedge clock_in);
  endtask : do_reset

  task automatic wait_q(input int lim);
    int i;
    for (i = 0; i < lim && (exp_start.size() + exp_read.size()) > 0; i++) @(posedge clock_in);
    check("pending commands", exp_start.size() + exp_read.size(), 0);
  endtask : wait_q

  // random stalls from the row drivers stretch timing but lose nothing
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    stall <= rnd_on & (($random(seed) & 3) == 0);
  end

  // monitor: each taken word is matched to the oldest note of its kind while notes of that kind remain
  always @(posedge clock_in) begin
    if (g_xfer) xcnt <= xcnt + 1;
    else if (xcnt != 0) begin
      check("xfer length", xcnt, XFER_CYC);
      xcnt <= 0;
    end
    if (took && word[12:11] == K_START && exp_start.size() > 0) begin
      check("start word", word, exp_start.pop_front());
      if (last >= 0) check("row spacing", cyc - last, ROW_CYC);
      last = cyc;
    end else if (took && word[12:11] != K_START && exp_read.size() > 0)
      check("read word", word, exp_read.pop_front());
  end

  initial begin
    #(40 * 60000);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    int i;
    do_reset();
    // rolling, continuous: start wave then read wave in the same row order
    continuous_in <= 1'b1;
    for (i = 0; i < 4; i++) exp_start.push_back({1'b0, K_START, 11'(i)});
    for (i = 0; i < 2; i++) exp_read.push_back({1'b1, K_RSIG, 11'(i)});
    acq_run_in <= 1'b1;
    @(posedge clock_in);
    global_sel_in <= 1'b1;
    // busy lags the state by one edge
    @(posedge clock_in);
    #1;
    check("busy rolling", busy, 1);
    wait_q(2000);
    check("mode stays rolling", mode_g, 0);
    do_reset();
    // global, overlap, with stalls and a random exposure length
    continuous_in <= 1'b0;
    overlap_in <= 1'b1;
    exp_rows_in <= 16'h0002 + EXP_W'($random(seed) & 1);
    repeat (3) @(posedge clock_in);
    check("clean in idle", g_clean, 1);
    check("no exposure in idle", g_exp, 0);
    for (i = 0; i < 2; i++) exp_read.push_back({1'b0, K_RREF, 11'(i)});
    rnd_on <= 1'b1;
    acq_run_in <= 1'b1;
    for (i = 0; i < 10 && !g_exp; i++) @(posedge clock_in);
    #1;
    check("global exposing", g_exp, 1);
    check("clean released", g_clean, 0);
    check("mode global", mode_g, 1);
    check("variant mode", ro_mode, 0);
    check("variant expose", ro_exp, 0);
    for (i = 0; i < 2000 && !g_xfer; i++) @(posedge clock_in);
    #1;
    check("xfer ends exposure", g_exp, 0);
    wait_q(3000);
    for (i = 0; i < ROW_CYC && !g_exp; i++) @(posedge clock_in);
    #1;
    check("overlap exposure", g_exp, 1);
    check("xfer held off", g_xfer, 0);
    rnd_on <= 1'b0;
    end_of_test();
  end
endmodule : srseq_seq_bench
